// [hw/tlc_ctrl.v]
// Purpose: coprocessor control for tlb maintenance, cache way lock and coupled memory regions
// Assumes: one coprocessor access per cycle, inputs synchronous to sys_clk
// Notes:   reads return data one cycle after the request
`timescale 1ns/10ps
`include "tlc_defines.vh"

// Functional notes
// - tlb operations register write only
// - decode six tlb operations
// - whole invalidate spares lockdown entries
// - single invalidate removes matching entry anywhere
// - instruction/data variants hit any entry
// - one buffer, set-associative plus lockdown
// - minor 0 way lock, 1 region
// - opcode 0 data, 1 instruction copy
// - lock bit blocks allocation into way unless all four are locked
// - reset clears all lock bits
// - all locked fills way 3
// - bits 15:4 read ones, upper zero
// - fills go only to unlocked ways unless all four are locked
// - one instruction, one data region
// - data region disabled at reset
// - boot pin sets instruction enable
// - region opcode 0 data, 1 instruction
// - base, size code, enable layout
// - size code 3 to 11 valid
// - disabled region not accessed
module tlc_ctrl #(
    parameter SA_ENTRIES = 32,
    parameter LK_ENTRIES = 8
) (
    input  wire        sys_clk,
    input  wire        reset_n,
    input  wire        coprocWriteInstr,
    input  wire        coprocReadInstr,
    input  wire [3:0]  coprocPrimaryRegSel,
    input  wire [3:0]  coprocMinorRegSel,
    input  wire [2:0]  coprocOpcodeSel,
    input  wire [31:0] coprocWriteData,
    input  wire [3:0]  dataRegionSizeIn,
    input  wire [3:0]  instrRegionSizeIn,
    input  wire        bootFromRegionIn,
    input  wire        tlbFillValid,
    input  wire        tlbFillLock,
    input  wire [4:0]  tlbFillIndex,
    input  wire [19:0] tlbFillTag,
    input  wire [1:0]  dataReplWay,
    input  wire [1:0]  instrReplWay,
    input  wire        dataMemReq,
    input  wire [31:0] dataMemAddr,
    input  wire        instrMemReq,
    input  wire [31:0] instrMemAddr,
    output reg  [31:0] coprocReadData,
    output reg         coprocReadValid,
    output reg  [1:0]  dataFillWay,
    output reg  [1:0]  instrFillWay,
    output reg         dataRegionSel,
    output reg         instrRegionSel,
    output reg         dataRegionEnable,
    output reg         instrRegionEnable,
    output reg  [SA_ENTRIES-1:0] tlbSaValid,
    output reg  [LK_ENTRIES-1:0] tlbLkValid
);
    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    // size code to count of base bits that must match (20 for 4KB down to 12 for 1MB)
    function [4:0] maskBits;
        input [3:0] code;
        begin
            if (code >= `TLC_SIZE_MIN && code <= `TLC_SIZE_MAX)
                maskBits = 5'd20 - {1'b0, code} + 5'd3;
            else
                maskBits = 5'd0;
        end
    endfunction

    function regionHit;
        input [19:0] base;
        input [31:0] addr;
        input [3:0]  code;
        reg   [19:0] mask;
        begin
            mask      = ~(20'hfffff >> maskBits(code));
            regionHit = (maskBits(code) != 5'd0) && ((addr[31:12] & mask) == (base & mask));
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg  [3:0]  dataLock_r;
    reg  [3:0]  instrLock_r;
    reg  [19:0] dataBase_r;
    reg  [19:0] instrBase_r;
    reg         dataEn_r;
    reg         instrEn_r;
    reg         bootPending_r;
    reg  [31:0] readNxt;
    wire [1:0]  dataWayNxt;
    wire [1:0]  instrWayNxt;
    wire [SA_ENTRIES-1:0] saValid;
    wire [LK_ENTRIES-1:0] lkValid;

    // ----------------------------------------------------------------
    // access decode
    // ----------------------------------------------------------------
    wire priTlb   = coprocPrimaryRegSel == `TLC_PRI_TLBOP;
    wire priLock  = coprocPrimaryRegSel == `TLC_PRI_LOCKREG;
    wire opDataSel  = coprocOpcodeSel == `TLC_OP_DATA_COPY;
    wire opInstrSel = coprocOpcodeSel == `TLC_OP_INSTR_COPY;
    wire minWay   = coprocMinorRegSel == `TLC_MIN_WAYLOCK;
    wire minReg   = coprocMinorRegSel == `TLC_MIN_REGION;
    wire tlbMinorOk = (coprocMinorRegSel == `TLC_MIN_UNIFIED) ||
                      (coprocMinorRegSel == `TLC_MIN_INSTR) ||
                      (coprocMinorRegSel == `TLC_MIN_DATA);
    wire tlbWr    = coprocWriteInstr && priTlb && tlbMinorOk;
    wire invAll   = tlbWr && coprocOpcodeSel == `TLC_OP_ALL;
    wire invSingle = tlbWr && coprocOpcodeSel == `TLC_OP_SINGLE;
    wire lockWr   = coprocWriteInstr && priLock;
    wire dLockWr  = lockWr && minWay && opDataSel;
    wire iLockWr  = lockWr && minWay && opInstrSel;
    wire dRegWr   = lockWr && minReg && opDataSel;
    wire iRegWr   = lockWr && minReg && opInstrSel;

    // ----------------------------------------------------------------
    // tlb store and fill way pickers
    // ----------------------------------------------------------------
    tlc_tlb_store #(
        .SA_ENTRIES (SA_ENTRIES),
        .LK_ENTRIES (LK_ENTRIES),
        .TAG_W      (20)
    ) u_tlb (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .fillValid  (tlbFillValid),
        .fillLock   (tlbFillLock),
        .fillIndex  (tlbFillIndex),
        .fillTag    (tlbFillTag),
        .invAll     (invAll),
        .invSingle  (invSingle),
        .invTag     (coprocWriteData[31:12]),
        .saValid    (saValid),
        .lkValid    (lkValid)
    );

    tlc_fill_way u_dway (
        .lockBits (dataLock_r),
        .replWay  (dataReplWay),
        .fillWay  (dataWayNxt)
    );

    tlc_fill_way u_iway (
        .lockBits (instrLock_r),
        .replWay  (instrReplWay),
        .fillWay  (instrWayNxt)
    );

    // ----------------------------------------------------------------
    // lock registers
    // ----------------------------------------------------------------
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dataLock_r  <= `TLC_LOCK_RESET;
            instrLock_r <= `TLC_LOCK_RESET;
        end else begin
            if (dLockWr) begin
                dataLock_r <= coprocWriteData[3:0];
            end
            if (iLockWr) begin
                instrLock_r <= coprocWriteData[3:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // region registers
    // ----------------------------------------------------------------
    // the boot strap is sampled after release, never under the async reset
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dataBase_r    <= 20'h00000;
            instrBase_r   <= 20'h00000;
            dataEn_r      <= 1'b0;
            instrEn_r     <= 1'b0;
            bootPending_r <= 1'b1;
        end else begin
            bootPending_r <= 1'b0;
            if (bootPending_r && !iRegWr) begin
                instrEn_r <= bootFromRegionIn;
            end
            if (dRegWr) begin
                dataBase_r <= coprocWriteData[`TLC_BASE_MSB:`TLC_BASE_LSB];
                dataEn_r   <= coprocWriteData[`TLC_ENABLE_BIT];
            end
            if (iRegWr) begin
                instrBase_r <= coprocWriteData[`TLC_BASE_MSB:`TLC_BASE_LSB];
                instrEn_r   <= coprocWriteData[`TLC_ENABLE_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always @* begin
        readNxt = 32'h00000000;
        if (priLock && minWay && opDataSel) begin
            readNxt = {16'h0000, `TLC_LOCK_ONES, dataLock_r};
        end else if (priLock && minWay && opInstrSel) begin
            readNxt = {16'h0000, `TLC_LOCK_ONES, instrLock_r};
        end else if (priLock && minReg && opDataSel) begin
            readNxt = {dataBase_r, 6'h00, dataRegionSizeIn, 1'b0, dataEn_r};
        end else if (priLock && minReg && opInstrSel) begin
            readNxt = {instrBase_r, 6'h00, instrRegionSizeIn, 1'b0, instrEn_r};
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            coprocReadData    <= 32'h00000000;
            coprocReadValid   <= 1'b0;
            dataFillWay       <= 2'h0;
            instrFillWay      <= 2'h0;
            dataRegionSel     <= 1'b0;
            instrRegionSel    <= 1'b0;
            dataRegionEnable  <= 1'b0;
            instrRegionEnable <= 1'b0;
            tlbSaValid        <= {SA_ENTRIES{1'b0}};
            tlbLkValid        <= {LK_ENTRIES{1'b0}};
        end else begin
            coprocReadValid   <= coprocReadInstr;
            if (coprocReadInstr) begin
                coprocReadData <= readNxt;
            end
            dataFillWay       <= dataWayNxt;
            instrFillWay      <= instrWayNxt;
            dataRegionSel     <= dataMemReq && dataEn_r &&
                                 regionHit(dataBase_r, dataMemAddr, dataRegionSizeIn);
            instrRegionSel    <= instrMemReq && instrEn_r &&
                                 regionHit(instrBase_r, instrMemAddr, instrRegionSizeIn);
            dataRegionEnable  <= dataEn_r;
            instrRegionEnable <= instrEn_r;
            tlbSaValid        <= saValid;
            tlbLkValid        <= lkValid;
        end
    end
endmodule // tlc_ctrl

// [include/tlc_defines.vh]
// Purpose: constants for the tlb, cache way lock and coupled memory region control block
// Assumes: coprocessor register numbers are 4-bit, opcode select is 3-bit
// Notes:   included by the control and fill way design files of the block
`ifndef TLC_DEFINES_VH
`define TLC_DEFINES_VH

// ----------------------------------------------------------------
// primary register numbers
// ----------------------------------------------------------------
`define TLC_PRI_TLBOP        4'h8
`define TLC_PRI_LOCKREG      4'h9

// ----------------------------------------------------------------
// minor register numbers
// ----------------------------------------------------------------
`define TLC_MIN_UNIFIED      4'h7
`define TLC_MIN_INSTR        4'h5
`define TLC_MIN_DATA         4'h6
`define TLC_MIN_WAYLOCK      4'h0
`define TLC_MIN_REGION       4'h1

// ----------------------------------------------------------------
// opcode select values
// ----------------------------------------------------------------
`define TLC_OP_ALL           3'h0
`define TLC_OP_SINGLE        3'h1
`define TLC_OP_DATA_COPY     3'h0
`define TLC_OP_INSTR_COPY    3'h1

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define TLC_LOCK_ONES        12'hfff
`define TLC_LOCK_RESET       4'h0
`define TLC_BASE_MSB         31
`define TLC_BASE_LSB         12
`define TLC_SIZE_MSB         5
`define TLC_SIZE_LSB         2
`define TLC_ENABLE_BIT       0
`define TLC_SIZE_ABSENT      4'h0
`define TLC_SIZE_MIN         4'h3
`define TLC_SIZE_MAX         4'hb
`define TLC_FILL_WAY_ALL     2'h3

`endif

// [hw/tlc_tlb_store.v]
// Purpose: shared translation buffer tag store with set-associative and lockdown parts
// Assumes: entries loaded by a table walk port, lockdown part fully associative
// Notes:   only invalidation and presence are modelled; no translation data
`timescale 1ns/10ps
module tlc_tlb_store #(
    parameter SA_ENTRIES = 32,
    parameter LK_ENTRIES = 8,
    parameter TAG_W      = 20
) (
    input  wire                 sys_clk,
    input  wire                 reset_n,
    input  wire                 fillValid,
    input  wire                 fillLock,
    input  wire [4:0]           fillIndex,
    input  wire [TAG_W-1:0]     fillTag,
    input  wire                 invAll,
    input  wire                 invSingle,
    input  wire [TAG_W-1:0]     invTag,
    output wire [SA_ENTRIES-1:0] saValid,
    output wire [LK_ENTRIES-1:0] lkValid
);
    reg [TAG_W-1:0]      saTag [0:SA_ENTRIES-1];
    reg [TAG_W-1:0]      lkTag [0:LK_ENTRIES-1];
    reg [SA_ENTRIES-1:0] saValid_r;
    reg [LK_ENTRIES-1:0] lkValid_r;
    assign saValid = saValid_r;
    assign lkValid = lkValid_r;

    // ----------------------------------------------------------------
    // set-associative part
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < SA_ENTRIES; i = i + 1) begin : g_sa
            always @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    saValid_r[i] <= 1'b0;
                    saTag[i]     <= {TAG_W{1'b0}};
                end else if (invAll) begin
                    saValid_r[i] <= 1'b0;
                end else if (invSingle && saTag[i] == invTag) begin
                    saValid_r[i] <= 1'b0;
                end else if (fillValid && !fillLock && fillIndex == i) begin
                    saValid_r[i] <= 1'b1;
                    saTag[i]     <= fillTag;
                end
            end
        end
        // ----------------------------------------------------------------
        // lockdown part, untouched by whole invalidate
        // ----------------------------------------------------------------
        for (i = 0; i < LK_ENTRIES; i = i + 1) begin : g_lk
            always @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    lkValid_r[i] <= 1'b0;
                    lkTag[i]     <= {TAG_W{1'b0}};
                end else if (invSingle && lkTag[i] == invTag) begin
                    lkValid_r[i] <= 1'b0;
                end else if (fillValid && fillLock && fillIndex[2:0] == i) begin
                    lkValid_r[i] <= 1'b1;
                    lkTag[i]     <= fillTag;
                end
            end
        end
    endgenerate
endmodule // tlc_tlb_store

// [hw/tlc_fill_way.v]
// Purpose: pick the linefill way from the way lock bits
// Assumes: replacement pointer supplied by the cache
// Notes:   purely combinational
`timescale 1ns/10ps
`include "tlc_defines.vh"
module tlc_fill_way (
    input  wire [3:0] lockBits,
    input  wire [1:0] replWay,
    output reg  [1:0] fillWay
);
    integer k;
    reg     found;
    reg [1:0] cand;
    always @* begin
        fillWay = replWay;
        found   = 1'b0;
        cand    = 2'h0;
        if (&lockBits) begin
            fillWay = `TLC_FILL_WAY_ALL;
        end else if (lockBits[replWay]) begin
            for (k = 1; k < 4; k = k + 1) begin
                cand = replWay + k[1:0];
                if (!found && !lockBits[cand]) begin
                    fillWay = cand;
                    found   = 1'b1;
                end
            end
        end
    end
endmodule // tlc_fill_way

// [dv/tlc_ctrl_chk.sv]
// Purpose: port-level checks on tlc_ctrl
// Assumes: one clock, async active-low reset
// Notes:   a shadow of the data way lock lines up with the registered fill way
`timescale 1ns/10ps
`include "tlc_defines.vh"
module tlc_ctrl_chk #(
    parameter SA_ENTRIES = 32,
    parameter LK_ENTRIES = 8
) (
    input logic                  sys_clk,
    input logic                  reset_n,
    input logic                  coprocWriteInstr,
    input logic                  coprocReadInstr,
    input logic [3:0]            coprocPrimaryRegSel,
    input logic [3:0]            coprocMinorRegSel,
    input logic [2:0]            coprocOpcodeSel,
    input logic [31:0]           coprocWriteData,
    input logic                  bootFromRegionIn,
    input logic                  tlbFillValid,
    input logic [1:0]            dataReplWay,
    input logic [31:0]           coprocReadData,
    input logic                  coprocReadValid,
    input logic [1:0]            dataFillWay,
    input logic                  dataRegionEnable,
    input logic                  instrRegionEnable,
    input logic [SA_ENTRIES-1:0] tlbSaValid,
    input logic [LK_ENTRIES-1:0] tlbLkValid
);
    logic [3:0] dLock_r;
    logic [3:0] dLockD_r;
    logic [1:0] replD_r;
    logic       lockSel;
    logic       tlbSel;
    assign lockSel = coprocPrimaryRegSel == `TLC_PRI_LOCKREG && coprocMinorRegSel == 4'h0;
    assign tlbSel = coprocPrimaryRegSel == `TLC_PRI_TLBOP;

    // delayed one step: the fill way is registered from the lock state
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dLock_r  <= `TLC_LOCK_RESET;
            dLockD_r <= `TLC_LOCK_RESET;
            replD_r  <= 2'h0;
        end else begin
            if (coprocWriteInstr && lockSel && coprocOpcodeSel == 3'h0)
                dLock_r <= coprocWriteData[3:0];
            dLockD_r <= dLock_r;
            replD_r  <= dataReplWay;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_inv_all;
        coprocWriteInstr && tlbSel && coprocOpcodeSel == 3'h0 && !tlbFillValid
        && coprocMinorRegSel inside {4'h5, 4'h6, 4'h7} ##1 !tlbFillValid;
    endsequence

    a_read_answer: assert property (coprocReadInstr |=> coprocReadValid)
        else $error("read answer missing");
    a_lock_ones: assert property (coprocReadInstr && lockSel && coprocOpcodeSel[2:1] == 2'h0
        |=> coprocReadData[31:4] == 28'h0000fff)
        else $error("lock upper bits wrong");
    a_dlock_back: assert property (coprocReadInstr && lockSel && coprocOpcodeSel == 3'h0
        |=> coprocReadData[3:0] == $past(dLock_r))
        else $error("data lock readback wrong");
    a_tlb_rd_zero: assert property (coprocReadInstr && tlbSel |=> coprocReadData == 32'h0)
        else $error("tlb op read not zero");
    a_fill_all: assert property (dLockD_r == 4'hf |-> dataFillWay == 2'h3)
        else $error("all locked fill not way 3");
    a_fill_skip: assert property (dLockD_r != 4'hf |-> !dLockD_r[dataFillWay])
        else $error("fill into locked way");
    a_fill_repl: assert property (dLockD_r != 4'hf && !dLockD_r[replD_r]
        |-> dataFillWay == replD_r)
        else $error("unlocked way not used");
    a_inv_all: assert property (s_inv_all |=> tlbSaValid == '0 && $stable(tlbLkValid))
        else $error("invalidate all wrong");
    a_dreg_reset: assert property ($rose(reset_n) |-> !dataRegionEnable [*3])
        else $error("data region on after reset");
    a_boot_enable: assert property ($rose(reset_n)
        |-> ##2 instrRegionEnable == bootFromRegionIn)
        else $error("boot enable wrong");
endmodule // tlc_ctrl_chk

bind tlc_ctrl tlc_ctrl_chk #(.SA_ENTRIES(SA_ENTRIES), .LK_ENTRIES(LK_ENTRIES)) u_chk (
    .sys_clk, .reset_n, .coprocWriteInstr, .coprocReadInstr, .coprocPrimaryRegSel,
    .coprocMinorRegSel, .coprocOpcodeSel, .coprocWriteData, .bootFromRegionIn, .tlbFillValid,
    .dataReplWay, .coprocReadData, .coprocReadValid, .dataFillWay, .dataRegionEnable,
    .instrRegionEnable, .tlbSaValid, .tlbLkValid);

// [dv/tlc_core_model.sv]
// Purpose: core model issuing coprocessor reads and writes
// Assumes: one access per call, launched just after a rising edge
// Notes:   fields are inverted once taken, so stale values never look valid
`timescale 1ns/10ps
`include "tlc_defines.vh"
module tlc_core_model (
    input  logic        sys_clk,
    input  logic [31:0] coprocReadData,
    input  logic        coprocReadValid,
    output logic        coprocWriteInstr,
    output logic        coprocReadInstr,
    output logic [3:0]  coprocPrimaryRegSel,
    output logic [3:0]  coprocMinorRegSel,
    output logic [2:0]  coprocOpcodeSel,
    output logic [31:0] coprocWriteData
);
    logic [42:0] fields = '0;
    assign {coprocPrimaryRegSel, coprocMinorRegSel, coprocOpcodeSel, coprocWriteData} = fields;
    initial begin
        coprocWriteInstr = 1'b0;
        coprocReadInstr = 1'b0;
    end

    task automatic op(input logic isRd, input logic [3:0] pri, input logic [3:0] mnr,
        input logic [2:0] opc, input logic [31:0] wd, output logic [31:0] rd,
        output logic vld);
        @(posedge sys_clk);
        {coprocReadInstr, coprocWriteInstr} <= {isRd, !isRd};
        fields <= {pri, mnr, opc, wd};
        @(posedge sys_clk);
        {coprocReadInstr, coprocWriteInstr} <= 2'b00;
        fields <= ~{pri, mnr, opc, wd};
        #1;
        rd = coprocReadData;
        vld = coprocReadValid;
    endtask

    // read, change lock bits, write back
    task automatic rmw(input logic [2:0] opc, input logic [3:0] setB, input logic [3:0] clrB);
        logic [31:0] cur;
        logic        vld;
        op(1'b1, `TLC_PRI_LOCKREG, 4'h0, opc, 32'h0, cur, vld);
        // reserved upper bits go back as zero
        op(1'b0, `TLC_PRI_LOCKREG, 4'h0, opc, {16'h0, cur[15:4], (cur[3:0] | setB) & ~clrB},
            cur, vld);
    endtask
endmodule // tlc_core_model

// [dv/test_tlc_ctrl.sv]
// Purpose: self-checking bench for tlc_ctrl
// Assumes: every coprocessor access goes through the core model
// Notes:   a mid-run reset checks the boot strap low
`timescale 1ns/10ps
`include "tlc_defines.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; \
    $display("mismatch at %0t: got %h want %h", $time, a, e); end end
module test_tlc_ctrl;
    localparam logic [3:0] PT = `TLC_PRI_TLBOP;
    localparam logic [3:0] PL = `TLC_PRI_LOCKREG;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  dataRegionSizeIn = 4'h5;
    logic [3:0]  instrRegionSizeIn = 4'h3;
    logic        bootFromRegionIn = 1'b1;
    logic        tlbFillValid = 1'b0;
    logic        tlbFillLock = 1'b0;
    logic [4:0]  tlbFillIndex = 5'h00;
    logic [19:0] tlbFillTag = 20'h00000;
    logic [1:0]  dataReplWay = 2'h0;
    logic [1:0]  instrReplWay = 2'h0;
    logic        dataMemReq = 1'b0, instrMemReq = 1'b0, dataRegionSel, instrRegionSel;
    logic [31:0] dataMemAddr = 32'h0, instrMemAddr = 32'h0;
    logic        coprocWriteInstr, coprocReadInstr, coprocReadValid, rvalid;
    logic [3:0]  coprocPrimaryRegSel, coprocMinorRegSel;
    logic [2:0]  coprocOpcodeSel;
    logic [31:0] coprocWriteData, coprocReadData, rdata, tlbSaValid;
    logic        dataRegionEnable, instrRegionEnable;
    logic [1:0]  dataFillWay, instrFillWay;
    logic [7:0]  tlbLkValid;
    logic [3:0]  mins [3] = '{4'h7, 4'h5, 4'h6};
    int          mismatches = 0;
    int          check_count = 0;

    always #50 sys_clk = ~sys_clk;

    tlc_core_model core (.sys_clk, .coprocReadData, .coprocReadValid, .coprocWriteInstr,
        .coprocReadInstr, .coprocPrimaryRegSel, .coprocMinorRegSel, .coprocOpcodeSel,
        .coprocWriteData);
    tlc_ctrl #(.SA_ENTRIES(32), .LK_ENTRIES(8)) dut (.sys_clk, .reset_n, .coprocWriteInstr,
        .coprocReadInstr, .coprocPrimaryRegSel, .coprocMinorRegSel, .coprocOpcodeSel,
        .coprocWriteData, .dataRegionSizeIn, .instrRegionSizeIn, .bootFromRegionIn,
        .tlbFillValid, .tlbFillLock, .tlbFillIndex, .tlbFillTag, .dataReplWay, .instrReplWay,
        .dataMemReq, .dataMemAddr, .instrMemReq, .instrMemAddr,
        .coprocReadData, .coprocReadValid, .dataFillWay, .instrFillWay, .dataRegionSel,
        .instrRegionSel, .dataRegionEnable, .instrRegionEnable, .tlbSaValid, .tlbLkValid);

    task automatic settle;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic rd(input logic [3:0] p, input logic [3:0] m, input logic [2:0] o);
        core.op(1'b1, p, m, o, 32'h0, rdata, rvalid);
    endtask
    task automatic wr(input logic [3:0] p, input logic [3:0] m, input logic [2:0] o,
        input logic [31:0] d);
        core.op(1'b0, p, m, o, d, rdata, rvalid);
    endtask
    task automatic fill(input logic lk, input logic [4:0] ix, input logic [19:0] tg);
        @(posedge sys_clk);
        {tlbFillValid, tlbFillLock, tlbFillIndex, tlbFillTag} <= {1'b1, lk, ix, tg};
        @(posedge sys_clk);
        tlbFillValid <= 1'b0;
    endtask

    task automatic probe(input logic [31:0] da, input logic [31:0] ia);
        @(posedge sys_clk);
        {dataMemReq, dataMemAddr, instrMemReq, instrMemAddr} <= {1'b1, da, 1'b1, ia};
        settle;
    endtask

    task automatic t_reset;
        rd(PL, 4'h0, 3'h0);
        `CHK(rvalid, 1'b1)
        `CHK(rdata, 32'h0000fff0)
        rd(PL, 4'h0, 3'h1);
        `CHK(rdata, 32'h0000fff0)
        rd(PL, 4'h1, 3'h0);
        `CHK(rdata[11:0], {6'h0, dataRegionSizeIn, 2'b00})
        `CHK(instrRegionEnable, 1'b1)
        $display("test reset done");
    endtask

    task automatic t_lock;
        // data side keeps one way free
        core.rmw(3'h0, 4'h7, 4'h0);
        core.rmw(3'h1, 4'hf, 4'h0);
        rd(PL, 4'h0, 3'h0);
        `CHK(rdata, 32'h0000fff7)
        for (int w = 0; w < 4; w++) begin
            @(posedge sys_clk);
            dataReplWay <= 2'(w);
            instrReplWay <= 2'(w);
            settle;
            `CHK(dataFillWay, 2'h3)
            `CHK(instrFillWay, 2'h3)
        end
        // replacement pointer sits on locked way 3, so the fill wraps to 0
        core.rmw(3'h0, 4'h8, 4'h7);
        settle;
        `CHK(dataFillWay, 2'h0)
        // open only way 0, fill there, then lock it
        @(posedge sys_clk);
        dataReplWay <= 2'h1;
        core.rmw(3'h0, 4'he, 4'h1);
        settle;
        `CHK(dataFillWay, 2'h0)
        core.rmw(3'h0, 4'h1, 4'h6);
        wr(PL, 4'h2, 3'h0, 32'h0000000f);
        rd(PL, 4'h0, 3'h0);
        `CHK(rdata, 32'h0000fff9)
        $display("test lock done");
    endtask

    task automatic t_region;
        wr(PL, 4'h1, 3'h0, 32'h12345fff);
        rd(PL, 4'h1, 3'h0);
        `CHK(rdata, {20'h12345, 6'h0, dataRegionSizeIn, 2'b01})
        `CHK(dataRegionEnable, 1'b1)
        probe(32'h12346000, 32'h0);
        `CHK(dataRegionSel, 1'b1)
        probe(32'h12348000, 32'h0);
        `CHK(dataRegionSel, 1'b0)
        @(posedge sys_clk);
        instrRegionSizeIn <= 4'hb;
        dataRegionSizeIn <= 4'hc;
        wr(PL, 4'h1, 3'h1, 32'hfff00ffe);
        rd(PL, 4'h1, 3'h1);
        `CHK(rdata, {20'hfff00, 6'h0, 4'hb, 2'b00})
        `CHK(instrRegionEnable, 1'b0)
        probe(32'h12346000, 32'hfff00000);
        `CHK(dataRegionSel, 1'b0)
        `CHK(instrRegionSel, 1'b0)
        $display("test region done");
    endtask

    task automatic t_tlb;
        fill(1'b1, 5'd2, 20'h00010);
        for (int i = 0; i < 3; i++) begin
            fill(1'b0, 5'd3, 20'h00030);
            settle;
            `CHK(tlbSaValid[3], 1'b1)
            wr(PT, mins[i], 3'h0, 32'h0);
            settle;
            `CHK(tlbSaValid, 32'h0)
            `CHK(tlbLkValid, 8'h04)
        end
        fill(1'b0, 5'd0, 20'h00010);
        fill(1'b0, 5'd1, 20'h00020);
        wr(PT, 4'h6, 3'h1, 32'h00010000);
        settle;
        `CHK(tlbSaValid[1:0], 2'b10)
        `CHK(tlbLkValid, 8'h00)
        for (int i = 0; i < 4; i++) fill(1'b0, 5'(4 + i), 20'h00100 + 20'(4 * i));
        for (int i = 0; i < 4; i++) wr(PT, 4'h7, 3'h1, {20'h00100 + 20'(4 * i), 12'h000});
        wr(PT, 4'h4, 3'h0, 32'h0);
        wr(PT, 4'h7, 3'h2, 32'h0);
        settle;
        `CHK(tlbSaValid[7:1], 7'h01)
        rd(PT, 4'h7, 3'h0);
        `CHK(rdata, 32'h0)
        $display("test tlb done");
    endtask

    // second reset with the strap low
    task automatic t_boot;
        @(posedge sys_clk);
        bootFromRegionIn <= 1'b0;
        reset_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        settle;
        `CHK(instrRegionEnable, 1'b0)
        `CHK(dataRegionEnable, 1'b0)
        rd(PL, 4'h0, 3'h1);
        `CHK(rdata, 32'h0000fff0)
        $display("test boot done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        settle;
        t_reset;
        t_lock;
        t_region;
        t_tlb;
        t_boot;
        results;
    end
    // whole run is under two hundred cycles; this leaves ample margin
    initial begin
        #200000;
        mismatches++;
        results;
    end
endmodule // test_tlc_ctrl
